// *** include/rp_if.sv ***
`timescale 1ns/1ps
interface rp_if;
   import rp_pkg::*;

   logic                 reg_wr;     // register write strobe
   logic                 reg_rd;     // register read strobe
   logic [RP_IDX_W-1:0]  reg_idx;    // register index
   logic [RP_DATA_W-1:0] reg_wdata;  // write byte
   logic [RP_DATA_W-1:0] reg_rdata;  // read byte
   logic                 fetch;      // opcode fetch at pc
   logic [RP_PC_W-1:0]   pc;         // program counter
   logic                 fetch_ack;  // answer to fetch
   logic                 redirect;   // branch to vector
   logic [RP_PC_W-1:0]   vector;     // vector address

   modport dev (
      input  reg_wr, reg_rd, reg_idx, reg_wdata, fetch, pc,
      output reg_rdata, fetch_ack, redirect, vector
   );

   modport host (
      output reg_wr, reg_rd, reg_idx, reg_wdata, fetch, pc,
      input  reg_rdata, fetch_ack, redirect, vector
   );

endinterface

// *** include/rp_pkg.sv ***
package rp_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int RP_PC_W   = 16;
   localparam int RP_DATA_W = 8;
   localparam int RP_IDX_W  = 3;
   localparam int RP_SLOTS  = 2;
   localparam int RP_AV_AW  = 4;
   localparam int RP_AV_DW  = 32;
   localparam int RP_CNT_W  = 8;

   // ----------------------------------------------------------------
   // device register indices on the link
   // ----------------------------------------------------------------
   localparam logic [RP_IDX_W-1:0] RP_IDX_A1_HI = 3'h0;
   localparam logic [RP_IDX_W-1:0] RP_IDX_A1_LO = 3'h1;
   localparam logic [RP_IDX_W-1:0] RP_IDX_A2_HI = 3'h2;
   localparam logic [RP_IDX_W-1:0] RP_IDX_A2_LO = 3'h3;
   localparam logic [RP_IDX_W-1:0] RP_IDX_EN    = 3'h4;
   localparam logic [RP_IDX_W-1:0] RP_IDX_MSEL  = 3'h5;

   // field positions
   localparam int RP_EN_SLOT1_BIT = 0;
   localparam int RP_EN_SLOT2_BIT = 1;
   localparam int RP_MSEL_BIT     = 0;

   // reset values
   localparam logic [RP_PC_W-1:0]   RP_ADDR_RST = 16'h0000;
   localparam logic [RP_SLOTS-1:0]  RP_EN_RST   = 2'h0;
   localparam logic                 RP_MSEL_RST = 1'b0;
   localparam logic [RP_DATA_W-1:0] RP_BYTE_0   = 8'h00;

   // ----------------------------------------------------------------
   // correction vectors
   // ----------------------------------------------------------------
   localparam logic [RP_PC_W-1:0] RP_VEC1_RAM = 16'h0100;
   localparam logic [RP_PC_W-1:0] RP_VEC2_RAM = 16'h0120;
   localparam logic [RP_PC_W-1:0] RP_VEC1_ROM = 16'hf100;
   localparam logic [RP_PC_W-1:0] RP_VEC2_ROM = 16'hf120;

   // ----------------------------------------------------------------
   // controller avalon map (word addresses)
   // ----------------------------------------------------------------
   localparam logic [RP_AV_AW-1:0] RP_AV_DEV_LAST = 4'h5;
   localparam logic [RP_AV_AW-1:0] RP_AV_STATUS   = 4'h8;
   localparam logic [RP_AV_DW-1:0] RP_AV_ZERO     = 32'h0000_0000;

   typedef enum logic [3:0] {
      RP_ST_IDLE  = 4'h1,
      RP_ST_ISSUE = 4'h2,
      RP_ST_CAPT  = 4'h4,
      RP_ST_DONE  = 4'h8
   } rp_state_t;

endpackage

// *** rtl/rp_patch_dev.sv ***
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - per-slot high and low address bytes
// - compare pc with enabled slots, redirect
// - exactly two independent slots with vectors
// - select bit picks RAM or ROM vectors
// - enable bits 0 and 1 gate slots
// - both disabled means no redirection
// - firmware loads addresses before enabling
// - firmware programs only ROM addresses
// - firmware never loads identical slot addresses
// - patch returns by three-byte absolute jump
module rp_patch_dev (
   input  wire logic                         clk,          // cpu clock
   input  wire logic                         rst,          // async reset
   rp_if.dev                                 lnk,          // core side
   output logic [rp_pkg::RP_SLOTS-1:0]       slot_enabled, // enable bits
   output logic                              vec_in_rom,   // vector memory select
   output logic [rp_pkg::RP_SLOTS-1:0]       last_hit      // slot of last redirect
);
   import rp_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a slot can only match while its own enable bit is set
   function automatic logic slot_hit(input logic en, input logic [RP_PC_W-1:0] a,
                                     input logic [RP_PC_W-1:0] pc);
      slot_hit = en && (a == pc);
   endfunction

   // vector table, one entry per slot and memory choice
   function automatic logic [RP_PC_W-1:0] vec_sel(input logic slot2, input logic rom);
      logic [RP_PC_W-1:0] v1;
      logic [RP_PC_W-1:0] v2;
      v1      = rom ? RP_VEC1_ROM : RP_VEC1_RAM;
      v2      = rom ? RP_VEC2_ROM : RP_VEC2_RAM;
      vec_sel = slot2 ? v2 : v1;
   endfunction

   // read view of one link register; spare bits and indices read as zero
   function automatic logic [RP_DATA_W-1:0] read_byte(input logic [RP_IDX_W-1:0] idx,
                                                      input logic [RP_PC_W-1:0]  a1,
                                                      input logic [RP_PC_W-1:0]  a2,
                                                      input logic [RP_SLOTS-1:0] en,
                                                      input logic                msel);
      read_byte = RP_BYTE_0;
      case (idx)
         RP_IDX_A1_HI: read_byte = a1[RP_PC_W-1:RP_DATA_W];
         RP_IDX_A1_LO: read_byte = a1[RP_DATA_W-1:0];
         RP_IDX_A2_HI: read_byte = a2[RP_PC_W-1:RP_DATA_W];
         RP_IDX_A2_LO: read_byte = a2[RP_DATA_W-1:0];
         RP_IDX_EN: begin
            read_byte[RP_EN_SLOT1_BIT] = en[0];
            read_byte[RP_EN_SLOT2_BIT] = en[1];
         end
         RP_IDX_MSEL: read_byte[RP_MSEL_BIT] = msel;
         default: ;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // slot priority
   // ----------------------------------------------------------------
   // lowest slot wins a double match; firmware keeps the addresses distinct
   function automatic logic [RP_SLOTS-1:0] first_hit(input logic [RP_SLOTS-1:0] m);
      first_hit = '0;
      for (int s = RP_SLOTS - 1; s >= 0; s--) begin
         if (m[s]) begin
            first_hit    = '0;
            first_hit[s] = 1'b1;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // one address per slot, high byte above low byte
   logic [RP_PC_W-1:0]   addr_q [RP_SLOTS];
   logic [RP_PC_W-1:0]   addr_d [RP_SLOTS];
   logic [RP_SLOTS-1:0]  en_q,   en_d;
   logic                 msel_q, msel_d;
   logic [RP_DATA_W-1:0] rdata_q, rdata_d;
   logic                 ack_q,  ack_d;
   logic                 redir_q, redir_d;
   logic [RP_PC_W-1:0]   vec_q,  vec_d;
   logic [RP_SLOTS-1:0]  hit_q,  hit_d;
   logic [RP_SLOTS-1:0]  slot_match;
   logic [RP_SLOTS-1:0]  win;

   // ----------------------------------------------------------------
   // per-slot comparators
   // ----------------------------------------------------------------
   // every slot compares on its own; priority is settled afterwards
   generate
      for (genvar s = 0; s < RP_SLOTS; s++) begin : g_slot
         assign slot_match[s] = slot_hit(en_q[s], addr_q[s], lnk.pc);
      end
   endgenerate

   // ----------------------------------------------------------------
   // register write
   // ----------------------------------------------------------------
   // address bytes may be written in either order
   always_comb begin
      addr_d  = addr_q;
      en_d    = en_q;
      msel_d  = msel_q;
      if (lnk.reg_wr) begin
         case (lnk.reg_idx)
            RP_IDX_A1_HI: addr_d[0][RP_PC_W-1:RP_DATA_W] = lnk.reg_wdata;
            RP_IDX_A1_LO: addr_d[0][RP_DATA_W-1:0]       = lnk.reg_wdata;
            RP_IDX_A2_HI: addr_d[1][RP_PC_W-1:RP_DATA_W] = lnk.reg_wdata;
            RP_IDX_A2_LO: addr_d[1][RP_DATA_W-1:0]       = lnk.reg_wdata;
            RP_IDX_EN: begin
               en_d[0] = lnk.reg_wdata[RP_EN_SLOT1_BIT];
               en_d[1] = lnk.reg_wdata[RP_EN_SLOT2_BIT];
            end
            RP_IDX_MSEL: msel_d = lnk.reg_wdata[RP_MSEL_BIT];
            default: ;
         endcase
      end
   end

   // addresses and enables clear together, so no slot is live after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q[0] <= RP_ADDR_RST;
         addr_q[1] <= RP_ADDR_RST;
         en_q      <= RP_EN_RST;
         msel_q    <= RP_MSEL_RST;
      end else begin
         addr_q    <= addr_d;
         en_q      <= en_d;
         msel_q    <= msel_d;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // the byte is registered and stands until the next read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (lnk.reg_rd) begin
         rdata_d = read_byte(lnk.reg_idx, addr_q[0], addr_q[1], en_q, msel_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= RP_BYTE_0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // fetch match
   // ----------------------------------------------------------------
   // the answer lags the fetch by one edge, so the core never sees a compare glitch
   always_comb begin
      win     = first_hit(slot_match);
      ack_d   = lnk.fetch;
      redir_d = 1'b0;
      vec_d   = vec_q;
      hit_d   = hit_q;
      if (lnk.fetch && (win != '0)) begin
         redir_d = 1'b1;
         vec_d   = vec_sel(win[RP_EN_SLOT2_BIT], msel_q);
         hit_d   = win;
      end
      // with both enables clear nothing matches, vectors stay plain memory
   end

   // ----------------------------------------------------------------
   // fetch state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q   <= 1'b0;
         redir_q <= 1'b0;
         vec_q   <= RP_ADDR_RST;
         hit_q   <= RP_EN_RST;
      end else begin
         ack_q   <= ack_d;
         redir_q <= redir_d;
         vec_q   <= vec_d;
         hit_q   <= hit_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // link outputs, each straight from a register
   assign lnk.reg_rdata = rdata_q;
   assign lnk.fetch_ack = ack_q;
   assign lnk.redirect  = redir_q;
   assign lnk.vector    = vec_q;

   // user-side taps, each straight from a register
   assign slot_enabled  = en_q;
   assign vec_in_rom    = msel_q;
   assign last_hit      = hit_q;

endmodule

// *** rtl/rp_patch_host.sv ***
`timescale 1ns/1ps
module rp_patch_host (
   input  wire logic                         clk,             // cpu clock
   input  wire logic                         rst,             // async reset
   rp_if.host                                lnk,             // to patch unit
   input  wire logic [rp_pkg::RP_AV_AW-1:0]  avs_address,     // word address
   input  wire logic                         avs_read,        // read request
   input  wire logic                         avs_write,       // write request
   input  wire logic [rp_pkg::RP_AV_DW-1:0]  avs_writedata,   // write data
   output logic      [rp_pkg::RP_AV_DW-1:0]  avs_readdata,    // read data
   output logic                              avs_waitrequest, // stall
   input  wire logic                         core_fetch,      // opcode fetch
   input  wire logic [rp_pkg::RP_PC_W-1:0]   core_pc,         // fetch address
   output logic                              core_ack,        // fetch answered
   output logic                              core_redirect,   // take vector
   output logic      [rp_pkg::RP_PC_W-1:0]   core_target      // vector address
);
   import rp_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rp_state_t            st_q, st_d;
   logic                 wr_q, wr_d;
   logic                 rd_q, rd_d;
   logic [RP_IDX_W-1:0]  idx_q, idx_d;
   logic [RP_DATA_W-1:0] wdata_q, wdata_d;
   logic [RP_AV_DW-1:0]  rdata_q, rdata_d;
   logic                 wait_q, wait_d;
   logic                 fetch_q, fetch_d;
   logic [RP_PC_W-1:0]   pc_q, pc_d;
   logic                 ack_q, ack_d;
   logic                 redir_q, redir_d;
   logic [RP_PC_W-1:0]   tgt_q, tgt_d;
   logic [RP_CNT_W-1:0]  cnt_q, cnt_d;

   // ----------------------------------------------------------------
   // avalon slave to device register link
   // ----------------------------------------------------------------
   // firmware order (addresses before enables, ROM-only, distinct) is software's job
   always_comb begin
      st_d    = st_q;
      wr_d    = 1'b0;
      rd_d    = 1'b0;
      idx_d   = idx_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      wait_d  = wait_q;
      case (st_q)
         RP_ST_IDLE: begin
            if (avs_read || avs_write) begin
               if (avs_address <= RP_AV_DEV_LAST) begin
                  wr_d    = avs_write;
                  rd_d    = avs_read;
                  idx_d   = avs_address[RP_IDX_W-1:0];
                  wdata_d = avs_writedata[RP_DATA_W-1:0];
                  st_d    = RP_ST_ISSUE;
               end else begin
                  rdata_d = (avs_address == RP_AV_STATUS) ?
                            {{(RP_AV_DW-RP_CNT_W-RP_PC_W){1'b0}}, cnt_q, tgt_q} : RP_AV_ZERO;
                  wait_d  = 1'b0;
                  st_d    = RP_ST_DONE;
               end
            end
         end
         RP_ST_ISSUE: st_d = RP_ST_CAPT;
         RP_ST_CAPT: begin
            rdata_d = {{(RP_AV_DW-RP_DATA_W){1'b0}}, lnk.reg_rdata};
            wait_d  = 1'b0;
            st_d    = RP_ST_DONE;
         end
         RP_ST_DONE: begin
            // request is still high at this edge; idle only looks again next cycle
            wait_d = 1'b1;
            st_d   = RP_ST_IDLE;
         end
         default: begin
            wait_d = 1'b1;
            st_d   = RP_ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // fetch path
   // ----------------------------------------------------------------
   // patch code returns with an absolute jump, seen here as an ordinary fetch
   always_comb begin
      fetch_d = core_fetch;
      pc_d    = core_pc;
      ack_d   = lnk.fetch_ack;
      redir_d = lnk.fetch_ack && lnk.redirect;
      tgt_d   = tgt_q;
      cnt_d   = cnt_q;
      if (lnk.fetch_ack && lnk.redirect) begin
         tgt_d = lnk.vector;
         cnt_d = cnt_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q    <= RP_ST_IDLE;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         idx_q   <= RP_IDX_A1_HI;
         wdata_q <= RP_BYTE_0;
         rdata_q <= RP_AV_ZERO;
         wait_q  <= 1'b1;
         fetch_q <= 1'b0;
         pc_q    <= RP_ADDR_RST;
         ack_q   <= 1'b0;
         redir_q <= 1'b0;
         tgt_q   <= RP_ADDR_RST;
         cnt_q   <= '0;
      end else begin
         st_q    <= st_d;
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         idx_q   <= idx_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         wait_q  <= wait_d;
         fetch_q <= fetch_d;
         pc_q    <= pc_d;
         ack_q   <= ack_d;
         redir_q <= redir_d;
         tgt_q   <= tgt_d;
         cnt_q   <= cnt_d;
      end
   end

   assign lnk.reg_wr      = wr_q;
   assign lnk.reg_rd      = rd_q;
   assign lnk.reg_idx     = idx_q;
   assign lnk.reg_wdata   = wdata_q;
   assign lnk.fetch       = fetch_q;
   assign lnk.pc          = pc_q;
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign core_ack        = ack_q;
   assign core_redirect   = redir_q;
   assign core_target     = tgt_q;

endmodule

// *** sim/rom_patch_redirect_bench.sv ***
`timescale 1ns/1ps
module rom_patch_redirect_bench;
   import rp_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, core_ack, core_redirect, vec_in_rom;
   logic        core_fetch = 1'b0;
   logic [15:0] core_pc = 16'h0;
   logic [15:0] core_target;
   logic [15:0] last_tgt = 16'h0;
   logic [7:0]  n_hits = 8'h00;
   logic [1:0]  slot_enabled, last_hit;
   logic [7:0]  addr_b [4] = '{8'h81, 8'h23, 8'h94, 8'h56};
   int          n_errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   rp_if lnk();
   rp_patch_host i_rp_patch_host (.clk(clk), .rst(rst), .lnk(lnk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_fetch(core_fetch),
      .core_pc(core_pc), .core_ack(core_ack), .core_redirect(core_redirect), .core_target(core_target));
   rp_patch_dev i_rp_patch_dev (.clk(clk), .rst(rst), .lnk(lnk), .slot_enabled(slot_enabled),
      .vec_in_rom(vec_in_rom), .last_hit(last_hit));
   rp_patch_asserts i_rp_patch_asserts (.clk(clk), .rst(rst), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_idx(lnk.reg_idx), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .fetch(lnk.fetch),
      .pc(lnk.pc), .fetch_ack(lnk.fetch_ack), .redirect(lnk.redirect), .vector(lnk.vector));

   always #20 clk = ~clk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task close_out;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // request held until waitrequest is sampled low at a rising edge
   task av(input logic [3:0] a, input logic wr, input logic [31:0] wd);
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // answer stands in the third cycle after the edge that takes the fetch
   task fetch(input logic [15:0] pc, input logic hit, input logic [15:0] tgt);
      @(posedge clk);
      core_fetch <= 1'b1;
      core_pc <= pc;
      @(posedge clk);
      core_fetch <= 1'b0;
      repeat (3) @(posedge clk);
      if (hit) begin
         last_tgt = tgt;
         n_hits++;
      end
      check("core_ack", core_ack, 1'b1);
      check("core_redirect", core_redirect, hit);
      check("core_target", core_target, last_tgt);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      for (int i = 0; i < 6; i++) begin
         av(i[3:0], 1'b0, 32'h0);
         check("reset reg", rd, 32'h0);
      end
      check("slot_enabled", slot_enabled, 2'h0);
      check("vec_in_rom", vec_in_rom, 1'b0);
   endtask

   task t_regs;
      for (int i = 0; i < 4; i++) av(i[3:0], 1'b1, {24'habcdef, addr_b[i]});
      for (int i = 0; i < 4; i++) begin
         av(i[3:0], 1'b0, 32'h0);
         check("slot address byte", rd, {24'h0, addr_b[i]});
      end
      av(4'h5, 1'b1, 32'hfe);
      av(4'h5, 1'b0, 32'h0);
      check("select read", rd, 32'h0);
      av(4'hc, 1'b1, 32'hff);
      av(4'hc, 1'b0, 32'h0);
      check("unmapped read", rd, 32'h0);
      av(4'h8, 1'b1, 32'hffff);
      av(4'h8, 1'b0, 32'h0);
      check("status", rd, 32'h0);
      fetch(16'h8123, 1'b0, 16'h0);
   endtask

   task t_slots;
      for (int m = 0; m < 2; m++) begin
         av(4'h5, 1'b1, m);
         check("vec_in_rom", vec_in_rom, m[0]);
         av(4'h4, 1'b1, 32'hfd);
         check("slot_enabled", slot_enabled, 2'h1);
         fetch(16'h8123, 1'b1, m ? 16'hf100 : 16'h0100);
         check("last_hit", last_hit, 2'h1);
         fetch(16'h9456, 1'b0, 16'h0);
         av(4'h4, 1'b1, 32'h2);
         fetch(16'h8123, 1'b0, 16'h0);
         fetch(16'h9456, 1'b1, m ? 16'hf120 : 16'h0120);
         check("last_hit", last_hit, 2'h2);
         av(4'h4, 1'b1, 32'h3);
         av(4'h4, 1'b0, 32'h0);
         check("enable read", rd, 32'h3);
         fetch(16'h9457, 1'b0, 16'h0);
         fetch(16'h8123, 1'b1, m ? 16'hf100 : 16'h0100);
      end
      av(4'h8, 1'b0, 32'h0);
      check("status", rd, {8'h0, n_hits, last_tgt});
   endtask

   task t_rereset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      last_tgt = 16'h0;
      n_hits = 8'h00;
      @(posedge clk);
      check("slot_enabled", slot_enabled, 2'h0);
      check("vec_in_rom", vec_in_rom, 1'b0);
      fetch(16'h8123, 1'b0, 16'h0);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         close_out;
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_slots;
      t_rereset;
      close_out;
   end
endmodule

// *** sim/rp_patch_asserts.sv ***
`timescale 1ns/1ps
module rp_patch_asserts (
   input wire logic                           clk,       // cpu clock
   input wire logic                           rst,       // async reset
   input wire logic                           reg_wr,    // write strobe
   input wire logic                           reg_rd,    // read strobe
   input wire logic [rp_pkg::RP_IDX_W-1:0]    reg_idx,   // register index
   input wire logic [rp_pkg::RP_DATA_W-1:0]   reg_wdata, // write byte
   input wire logic [rp_pkg::RP_DATA_W-1:0]   reg_rdata, // read byte
   input wire logic                           fetch,     // opcode fetch
   input wire logic [rp_pkg::RP_PC_W-1:0]     pc,        // fetch address
   input wire logic                           fetch_ack, // fetch answer
   input wire logic                           redirect,  // take vector
   input wire logic [rp_pkg::RP_PC_W-1:0]     vector     // vector address
);
   import rp_pkg::*;
   // ----------------------------------------------------------------
   // shadow of the device registers, seen from the link
   // ----------------------------------------------------------------
   logic [7:0]  sh_q [0:5];
   logic [7:0]  sh_d [0:5];
   logic [7:0]  exp_rd;
   logic [15:0] v1, v2;
   logic        hit1, hit2;

   always_comb begin
      sh_d = sh_q;
      if (reg_wr && reg_idx < 3'h6) sh_d[reg_idx] = reg_wdata;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) sh_q <= '{default: 8'h00};
      else sh_q <= sh_d;
   end
   always_comb begin
      case (reg_idx)
         3'h0, 3'h1, 3'h2, 3'h3: exp_rd = sh_q[reg_idx];
         3'h4: exp_rd = {6'h00, sh_q[4][1:0]};
         3'h5: exp_rd = {7'h00, sh_q[5][0]};
         default: exp_rd = 8'h00;
      endcase
   end
   assign v1 = sh_q[5][0] ? 16'hf100 : 16'h0100;
   assign v2 = sh_q[5][0] ? 16'hf120 : 16'h0120;
   // slot 1 wins if firmware breaks the distinct-address duty
   assign hit1 = fetch && sh_q[4][0] && pc == {sh_q[0], sh_q[1]};
   assign hit2 = fetch && sh_q[4][1] && pc == {sh_q[2], sh_q[3]} && !hit1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_redir(logic [15:0] v);
      fetch_ack && redirect && vector == v;
   endsequence

   a_fetch_answer: assert property (fetch |=> fetch_ack) else $error("fetch not answered");
   a_ack_cause: assert property (!fetch |=> !fetch_ack) else $error("answer without fetch");
   a_slot1_vector: assert property (hit1 |=> s_redir(v1)) else $error("slot 1 redirect wrong");
   a_slot2_vector: assert property (hit2 |=> s_redir(v2)) else $error("slot 2 redirect wrong");
   a_miss_quiet: assert property (fetch && !hit1 && !hit2 |=> fetch_ack && !redirect)
      else $error("redirect without enabled match");
   a_vector_holds: assert property (!redirect |-> $stable(vector)) else $error("vector moved");
   a_read_back: assert property (reg_rd |=> reg_rdata == $past(exp_rd)) else $error("read byte wrong");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read byte moved");
endmodule
